// >>> rtl/cursor_layer_dma_fetch.sv
// Cursor layer DMA fetch channel: register file, descriptor queue and
// burst-shaped memory reads feeding the pixel FIFO downstream.
// Assumes memory, FIFO and frame timing logic run on sys_clk_in.
// Operation
// - Head pointer register read/write, word address, two low bits read zero.
// - Full 32-bit read/write frame buffer start address register.
// - Descriptor fetch enable 1 fetches descriptors, 0 disables descriptor fetch.
// - Lookup fetch enable 1 fetches colour table by DMA, 0 disables it.
// - Transfer end interrupt control: 0 enables, 1 disables.
// - Descriptor loaded interrupt control: 0 enables, 1 disables.
// - Head queued interrupt control: 0 enables, 1 disables.
// - List end interrupt control: 1 enables, 0 disables.
// - Burst select 0 starts at one word of room, any burst type.
// - Burst select 1 waits four words, prefers four beats, max four.
// - Burst select 2 waits eight words, prefers eight beats, max eight.
// - Burst select 3 waits sixteen words, prefers sixteen beats.
// - Defined length only 0 allows 2 or 3 beat incr bursts, 1 forbids.
// - Lookup mode enable 0 selects direct colour, 1 indexed input.
// - Direct colour format codes 0 to 13 decode to their pixel depths.
// - Index depth codes 0 to 3 mean 1, 2, 4, 8 bits per pixel.
// - Writing add head queues head pointer; hardware clears it once added.
// - Head loaded flag sets on head descriptor load, clears on event register read.
`timescale 1ns/1ps
module cursor_layer_dma_fetch
	import cursor_dma_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic frame_start_in,
	input wire logic [15:0] frame_words_in,
	input wire logic [31:0] lut_base_in,
	input wire logic [5:0] fifo_space_in,
	output logic mem_req_out,
	output mem_cmd_s mem_cmd_out,
	input wire logic mem_ack_in,
	input wire logic mem_rvalid_in,
	input wire logic [31:0] mem_rdata_in,
	output logic pixel_valid_out,
	output pixel_s pixel_out,
	output irq_enable_s irq_enable_out,
	output logic [5:0] pixel_bits_out,
	output logic format_valid_out,
	output logic busy_out
);

	typedef enum logic [1:0] {st_idle, st_issue, st_request, st_data} state_e;
	typedef enum logic [1:0] {ph_lut, ph_desc, ph_pix} phase_e;

	// Engine state and the phase of the running frame
	state_e state_q;
	phase_e phase_q;
	// Software visible registers
	logic [31:0] head_q;
	logic [31:0] fb_start_q;
	logic [31:0] control_q;
	logic [31:0] next_q;
	logic [31:0] burst_q;
	logic [31:0] format_q;
	// Head queue request and sticky event flags
	logic pending_q;
	logic ev_xfer_q;
	logic ev_dscr_q;
	logic ev_head_q;
	logic ev_end_q;
	// Fetch engine working state
	logic [31:0] addr_q;
	logic [15:0] remain_q;
	logic [4:0] beats_q;
	logic from_head_q;
	logic [31:0] rdata_q;
	// Output flops
	logic mem_req_q;
	mem_cmd_s mem_cmd_q;
	logic pixel_valid_q;
	pixel_s pixel_q;
	irq_enable_s irq_enable_q;
	logic [5:0] pixel_bits_q;
	logic format_valid_q;
	logic busy_q;

	// Address decode of the register port
	// Exact match on the full address, so no register is aliased elsewhere
	wire hit_command = reg_addr_in == OFS_COMMAND;
	wire hit_chan = reg_addr_in == OFS_CHAN_STATUS;
	wire hit_events = reg_addr_in == OFS_EVENTS;
	wire hit_head = reg_addr_in == OFS_HEAD;
	wire hit_fb = reg_addr_in == OFS_FB_START;
	wire hit_control = reg_addr_in == OFS_CONTROL;
	wire hit_next = reg_addr_in == OFS_NEXT;
	wire hit_burst = reg_addr_in == OFS_BURST;
	wire hit_format = reg_addr_in == OFS_FORMAT;

	// Status words as software sees them
	logic [31:0] chan_word;
	logic [31:0] event_word;
	always_comb begin
		chan_word = RESET_VALUE;
		chan_word[BIT_ACTIVE] = busy_q;
		chan_word[BIT_PENDING] = pending_q;
		event_word = RESET_VALUE;
		event_word[EV_XFER] = ev_xfer_q;
		event_word[EV_DSCR] = ev_dscr_q;
		event_word[EV_HEAD] = ev_head_q;
		event_word[EV_END] = ev_end_q;
	end

	// Read selection; the command register is write-only and unmapped reads give zero
	wire [31:0] rd_mux = hit_head ? head_q :
		hit_fb ? fb_start_q :
		hit_control ? control_q :
		hit_next ? next_q :
		hit_burst ? burst_q :
		hit_format ? format_q :
		hit_chan ? chan_word :
		hit_events ? event_word : RESET_VALUE;

	// Configuration fields
	wire desc_needed = control_q[BIT_DESC_FETCH];
	wire lut_mode = format_q[BIT_LUT_MODE];
	wire lut_needed = control_q[BIT_LUT_FETCH] & lut_mode;
	wire [1:0] burst_length_select = burst_q[BURST_LENGTH_SELECT_LSB +: 2];
	wire defined_length_only = burst_q[BIT_DEFINED_LENGTH_ONLY];
	wire [3:0] rgb_code = format_q[RGB_LSB +: 4];
	wire [1:0] depth_code = format_q[DEPTH_LSB +: 2];

	// Room the pixel FIFO must offer before a read starts
	wire [5:0] room_needed = (burst_length_select == BURST_THRESHOLD_FOUR) ? WORDS_4 :
		(burst_length_select == BURST_THRESHOLD_EIGHT) ? WORDS_8 :
		(burst_length_select == BURST_THRESHOLD_SIXTEEN) ? WORDS_16 : WORDS_1;

	// Descriptor reads bypass the pixel FIFO and never wait for room
	// Lookup table words do land in the FIFO, so they wait like pixels
	wire space_ok = (phase_q == ph_desc) || (fifo_space_in >= room_needed);

	// Largest burst allowed now: in any-burst mode bounded by the room itself
	wire [5:0] room_cap = (fifo_space_in < WORDS_16) ? fifo_space_in : WORDS_16;
	wire [5:0] cap = (phase_q == ph_desc) ? WORDS_16 :
		(burst_length_select == BURST_ANY) ? room_cap : room_needed;
	// Never ask for more beats than the phase still needs
	wire [5:0] avail = (remain_q < {10'h000, cap}) ? remain_q[5:0] : cap;

	// Burst shape: fixed lengths first, short incr only when allowed
	wire short_ok = (avail >= WORDS_2) && !defined_length_only;
	burst_e pick_burst;
	assign pick_burst = (avail >= WORDS_16) ? burst_incr16 :
		(avail >= WORDS_8) ? burst_incr8 :
		(avail >= WORDS_4) ? burst_incr4 :
		short_ok ? burst_incr : burst_single;
	wire [5:0] pick_beats6 = (avail >= WORDS_16) ? WORDS_16 :
		(avail >= WORDS_8) ? WORDS_8 :
		(avail >= WORDS_4) ? WORDS_4 :
		short_ok ? avail : WORDS_1;
	wire [4:0] pick_beats = pick_beats6[4:0];

	// Phase sequencing: optional lookup table, optional descriptor, then pixels
	// Lookup mode off skips the table even when its fetch is enabled
	wire phase_done = (state_q == st_issue) && (remain_q == '0);
	phase_e start_phase;
	phase_e after_phase;
	phase_e tgt_phase;
	assign start_phase = lut_needed ? ph_lut : desc_needed ? ph_desc : ph_pix;
	assign after_phase = (phase_q == ph_lut && desc_needed) ? ph_desc : ph_pix;
	assign tgt_phase = (state_q == st_idle) ? start_phase : after_phase;

	// A queued head takes priority over the chained next pointer
	wire [31:0] desc_addr = pending_q ? head_q : next_q;
	wire [31:0] tgt_addr = (tgt_phase == ph_lut) ? lut_base_in :
		(tgt_phase == ph_desc) ? desc_addr : fb_start_q;
	wire [15:0] tgt_words = (tgt_phase == ph_lut) ? LUT_WORDS[depth_code] :
		(tgt_phase == ph_desc) ? DESC_WORDS : frame_words_in;
	wire tgt_from_head = (tgt_phase == ph_desc) && pending_q;

	// Descriptor words arrive as address, control, next
	// The word index comes from the remaining count, which saves a counter
	wire desc_beat = (state_q == st_data) && mem_rvalid_in && (phase_q == ph_desc);
	wire [1:0] desc_idx = 2'(DESC_WORDS - remain_q);
	wire desc_ld_addr = desc_beat && (desc_idx == 2'h0);
	wire desc_ld_ctrl = desc_beat && (desc_idx == 2'h1);
	wire desc_ld_next = desc_beat && (desc_idx == 2'h2);

	// Events of the channel
	// Each is a one-cycle pulse; the flags below make them sticky
	wire desc_done = phase_done && (phase_q == ph_desc);
	wire head_done = desc_done && from_head_q;
	wire pix_done = phase_done && (phase_q == ph_pix);
	wire list_end = pix_done && desc_needed && (next_q == '0);
	wire add_head = reg_wr_in && hit_command && reg_wdata_in[BIT_ADD_HEAD];
	wire ev_clear = reg_rd_in && hit_events;

	// Software writes, then descriptor loads, which win a same-cycle collision
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			head_q <= RESET_VALUE;
			fb_start_q <= RESET_VALUE;
			control_q <= RESET_VALUE;
			next_q <= RESET_VALUE;
			burst_q <= RESET_VALUE;
			format_q <= RESET_VALUE;
		end else begin
			if (reg_wr_in && hit_head) begin
				head_q <= reg_wdata_in & HEAD_MASK;
			end
			if (reg_wr_in && hit_fb) begin
				fb_start_q <= reg_wdata_in;
			end
			if (reg_wr_in && hit_control) begin
				control_q <= reg_wdata_in & CONTROL_MASK;
			end
			if (reg_wr_in && hit_next) begin
				next_q <= reg_wdata_in;
			end
			if (reg_wr_in && hit_burst) begin
				burst_q <= reg_wdata_in & BURST_MASK;
			end
			if (reg_wr_in && hit_format) begin
				format_q <= reg_wdata_in & FORMAT_MASK;
			end
			if (desc_ld_addr) begin
				fb_start_q <= mem_rdata_in;
			end
			if (desc_ld_ctrl) begin
				control_q <= mem_rdata_in & CONTROL_MASK;
			end
			if (desc_ld_next) begin
				next_q <= mem_rdata_in;
			end
		end
	end

	// Queue request and sticky events; a setting event beats a clear
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pending_q <= 1'b0;
			ev_xfer_q <= 1'b0;
			ev_dscr_q <= 1'b0;
			ev_head_q <= 1'b0;
			ev_end_q <= 1'b0;
		end else begin
			pending_q <= add_head | (pending_q & ~head_done);
			ev_xfer_q <= pix_done | (ev_xfer_q & ~ev_clear);
			ev_dscr_q <= desc_done | (ev_dscr_q & ~ev_clear);
			ev_head_q <= head_done | (ev_head_q & ~ev_clear);
			ev_end_q <= list_end | (ev_end_q & ~ev_clear);
		end
	end

	// Read data stands only in the cycle after the strobe
	// Zero elsewhere, so a shared read bus can be combined by or without a select
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= RESET_VALUE;
		end else begin
			rdata_q <= reg_rd_in ? rd_mux : RESET_VALUE;
		end
	end

	// Decoded enables and pixel depth, registered so outputs come from flops
	// An undefined direct colour code reports depth zero and drops format valid
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_enable_q <= '0;
			pixel_bits_q <= '0;
			format_valid_q <= 1'b0;
		end else begin
			irq_enable_q.transfer_end <= ~control_q[BIT_XFER_IRQ];
			irq_enable_q.descriptor_loaded <= ~control_q[BIT_DSCR_IRQ];
			irq_enable_q.head_queued <= ~control_q[BIT_HEAD_IRQ];
			irq_enable_q.list_end <= control_q[BIT_END_IRQ];
			if (lut_mode) begin
				pixel_bits_q <= LUT_BPP[depth_code];
				format_valid_q <= 1'b1;
			end else if (rgb_code <= RGB_LAST) begin
				pixel_bits_q <= RGB_BPP[rgb_code];
				format_valid_q <= 1'b1;
			end else begin
				pixel_bits_q <= '0;
				format_valid_q <= 1'b0;
			end
		end
	end

	// Fetch engine: one request at a time, beats counted against the issued length.
	// A frame start while busy is ignored, so a slow frame simply drops the next.
	// A channel reset or disable would need an abort path, which this block lacks.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= st_idle;
			phase_q <= ph_pix;
			addr_q <= RESET_VALUE;
			remain_q <= '0;
			beats_q <= '0;
			from_head_q <= 1'b0;
			mem_req_q <= 1'b0;
			mem_cmd_q <= '0;
			pixel_valid_q <= 1'b0;
			pixel_q <= '0;
			busy_q <= 1'b0;
		end else begin
			pixel_valid_q <= 1'b0;
			case (state_q)
				st_idle: begin
					if (frame_start_in) begin
						busy_q <= 1'b1;
						state_q <= st_issue;
						phase_q <= tgt_phase;
						addr_q <= tgt_addr;
						remain_q <= tgt_words;
						from_head_q <= tgt_from_head;
					end
				end
				// A phase change costs one cycle, which keeps one command outstanding
				st_issue: begin
					if (remain_q == '0) begin
						if (phase_q == ph_pix) begin
							busy_q <= 1'b0;
							state_q <= st_idle;
						end else begin
							phase_q <= tgt_phase;
							addr_q <= tgt_addr;
							remain_q <= tgt_words;
							from_head_q <= tgt_from_head;
						end
					end else if (space_ok) begin
						mem_req_q <= 1'b1;
						mem_cmd_q <= '{addr: addr_q, burst: pick_burst, beats: pick_beats};
						beats_q <= pick_beats;
						state_q <= st_request;
					end
				end
				// Command and request stand until the memory side accepts
				st_request: begin
					if (mem_ack_in) begin
						mem_req_q <= 1'b0;
						state_q <= st_data;
					end
				end
				// A burst ends on its own beat count; remain_q spans the whole phase
				st_data: begin
					if (mem_rvalid_in) begin
						addr_q <= addr_q + WORD_STEP;
						remain_q <= remain_q - 16'h0001;
						beats_q <= beats_q - 5'h01;
						if (phase_q != ph_desc) begin
							pixel_valid_q <= 1'b1;
							pixel_q <= '{data: mem_rdata_in, from_lut: phase_q == ph_lut};
						end
						if (beats_q == 5'h01) begin
							state_q <= st_issue;
						end
					end
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// Outputs straight from flops
	assign reg_rdata_out = rdata_q;
	assign mem_req_out = mem_req_q;
	assign mem_cmd_out = mem_cmd_q;
	assign pixel_valid_out = pixel_valid_q;
	assign pixel_out = pixel_q;
	assign irq_enable_out = irq_enable_q;
	assign pixel_bits_out = pixel_bits_q;
	assign format_valid_out = format_valid_q;
	assign busy_out = busy_q;

endmodule : cursor_layer_dma_fetch

// >>> rtl/cursor_dma_pkg.sv
// Shared constants and carriers for the cursor layer DMA fetch channel.
// Assumes a single 40 MHz clock domain and a full 32-bit register address.
package cursor_dma_pkg;
	// Register byte addresses
	localparam logic [31:0] OFS_COMMAND = 32'hf803_8340;
	localparam logic [31:0] OFS_CHAN_STATUS = 32'hf803_8348;
	localparam logic [31:0] OFS_EVENTS = 32'hf803_8358;
	localparam logic [31:0] OFS_HEAD = 32'hf803_835c;
	localparam logic [31:0] OFS_FB_START = 32'hf803_8360;
	localparam logic [31:0] OFS_CONTROL = 32'hf803_8364;
	localparam logic [31:0] OFS_NEXT = 32'hf803_8368;
	localparam logic [31:0] OFS_BURST = 32'hf803_836c;
	localparam logic [31:0] OFS_FORMAT = 32'hf803_8370;
	// Writable bit masks and reset value
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] HEAD_MASK = 32'hffff_fffc;
	localparam logic [31:0] CONTROL_MASK = 32'h0000_003f;
	localparam logic [31:0] BURST_MASK = 32'h0000_0130;
	localparam logic [31:0] FORMAT_MASK = 32'h0000_03f1;
	// Field positions
	localparam int BIT_DESC_FETCH = 0;
	localparam int BIT_LUT_FETCH = 1;
	localparam int BIT_XFER_IRQ = 2;
	localparam int BIT_DSCR_IRQ = 3;
	localparam int BIT_HEAD_IRQ = 4;
	localparam int BIT_END_IRQ = 5;
	localparam int BURST_LENGTH_SELECT_LSB = 4;
	localparam int BIT_DEFINED_LENGTH_ONLY = 8;
	localparam int BIT_LUT_MODE = 0;
	localparam int RGB_LSB = 4;
	localparam int DEPTH_LSB = 8;
	localparam int BIT_ADD_HEAD = 2;
	localparam int BIT_ACTIVE = 0;
	localparam int BIT_PENDING = 2;
	localparam int EV_XFER = 2;
	localparam int EV_DSCR = 3;
	localparam int EV_HEAD = 4;
	localparam int EV_END = 5;
	// Burst length select codes
	localparam logic [1:0] BURST_ANY = 2'h0;
	localparam logic [1:0] BURST_THRESHOLD_FOUR = 2'h1;
	localparam logic [1:0] BURST_THRESHOLD_EIGHT = 2'h2;
	localparam logic [1:0] BURST_THRESHOLD_SIXTEEN = 2'h3;
	// Word counts
	localparam logic [5:0] WORDS_1 = 6'h01;
	localparam logic [5:0] WORDS_2 = 6'h02;
	localparam logic [5:0] WORDS_4 = 6'h04;
	localparam logic [5:0] WORDS_8 = 6'h08;
	localparam logic [5:0] WORDS_16 = 6'h10;
	localparam logic [15:0] DESC_WORDS = 16'h0003;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [3:0] RGB_LAST = 4'hd;
	// Bits per pixel of each direct colour code, then of each index depth
	localparam logic [5:0] RGB_BPP [0:13] = '{6'h0c, 6'h10, 6'h10, 6'h10, 6'h10,
		6'h12, 6'h12, 6'h13, 6'h13, 6'h18, 6'h18, 6'h19, 6'h20, 6'h20};
	localparam logic [5:0] LUT_BPP [0:3] = '{6'h01, 6'h02, 6'h04, 6'h08};
	localparam logic [15:0] LUT_WORDS [0:3] = '{16'h0002, 16'h0004, 16'h0010, 16'h0100};

	typedef enum logic [2:0] {
		burst_single, burst_incr, burst_incr4, burst_incr8, burst_incr16
	} burst_e;

	typedef struct packed {
		logic [31:0] addr;
		burst_e burst;
		logic [4:0] beats;
	} mem_cmd_s;

	typedef struct packed {
		logic [31:0] data;
		logic from_lut;
	} pixel_s;

	typedef struct packed {
		logic list_end;
		logic head_queued;
		logic descriptor_loaded;
		logic transfer_end;
	} irq_enable_s;
endpackage : cursor_dma_pkg

// >>> dv/cursor_dma_assertions.sv
// Port checks for the cursor fetch channel.
// Assumes binding to cursor_layer_dma_fetch, one clock.
`timescale 1ns/1ps
module cursor_dma_assertions
	import cursor_dma_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic mem_req_out,
	input wire mem_cmd_s mem_cmd_out,
	input wire logic mem_ack_in,
	input wire irq_enable_s irq_enable_out,
	input wire logic [5:0] pixel_bits_out,
	input wire logic busy_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	logic [1:0] sel_q;
	logic defined_length_only_q;
	// Largest burst each policy may use; descriptor words never exceed it
	wire [4:0] cap_w = (sel_q == 2'h0) ? 5'h10 : 5'(5'h02 << sel_q);
	wire shape_ok = (mem_cmd_out.burst == burst_incr) ?
		(mem_cmd_out.beats == 5'h02 || mem_cmd_out.beats == 5'h03) :
		(mem_cmd_out.beats == 5'(5'h01 << mem_cmd_out.burst));
	wire [5:0] bpp_w = reg_wdata_in[0] ? LUT_BPP[reg_wdata_in[9:8]] : RGB_BPP[reg_wdata_in[7:4]];
	// Shadow of the burst policy; only software changes it
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_q <= 2'h0;
			defined_length_only_q <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == OFS_BURST) begin
			sel_q <= reg_wdata_in[5:4];
			defined_length_only_q <= reg_wdata_in[8];
		end
	end
	chk_cmd_hold: assert property (mem_req_out && !mem_ack_in |=>
		mem_req_out && $stable(mem_cmd_out)) else $error("command lost before accept");
	chk_req_release: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
		else $error("request held after accept");
	chk_burst_shape: assert property (mem_req_out |-> shape_ok)
		else $error("beats do not match burst kind");
	chk_defined_only: assert property (mem_req_out && defined_length_only_q |->
		mem_cmd_out.burst != burst_incr) else $error("undefined burst while forbidden");
	chk_beat_cap: assert property (mem_req_out |-> mem_cmd_out.beats <= cap_w)
		else $error("burst longer than policy allows");
	chk_head_rw: assert property (reg_wr_in && reg_addr_in == OFS_HEAD ##1
		reg_rd_in && reg_addr_in == OFS_HEAD |=> reg_rdata_out == ($past(reg_wdata_in, 2) & HEAD_MASK))
		else $error("head pointer readback wrong");
	chk_start_rw: assert property (reg_wr_in && reg_addr_in == OFS_FB_START && !busy_out ##1
		reg_rd_in && reg_addr_in == OFS_FB_START |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("start address readback wrong");
	chk_irq_decode: assert property (reg_wr_in && reg_addr_in == OFS_CONTROL && !busy_out ##1
		!reg_wr_in |=> {irq_enable_out, 2'h0} == 6'(($past(reg_wdata_in, 2) & 32'h0000_003c) ^ 32'h0000_001c))
		else $error("interrupt enable decode wrong");
	chk_bpp_decode: assert property (reg_wr_in && reg_addr_in == OFS_FORMAT &&
		(reg_wdata_in[0] || reg_wdata_in[7:4] <= RGB_LAST) ##1 !reg_wr_in |=>
		pixel_bits_out == $past(bpp_w, 2)) else $error("pixel depth decode wrong");
endmodule : cursor_dma_assertions
bind cursor_layer_dma_fetch cursor_dma_assertions chk_i (.sys_clk_in, .resetn_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_req_out, .mem_cmd_out,
	.mem_ack_in, .irq_enable_out, .pixel_bits_out, .busy_out);

// >>> dv/memory_model.sv
// System memory behind the bus matrix, one command at a time.
// Assumes each word reads back as its inverted byte address.
`timescale 1ns/1ps
module memory_model
	import cursor_dma_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic slow_in,
	input wire logic mem_req_in,
	input wire mem_cmd_s mem_cmd_in,
	output logic mem_ack_out,
	output logic mem_rvalid_out,
	output logic [31:0] mem_rdata_out
);
	logic [4:0] left_q;
	logic [31:0] addr_q;
	logic [1:0] wait_q;
	// Accept, then stream beats; slow mode accepts only every fourth cycle and streams a beat every other cycle
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_ack_out <= 1'b0;
			mem_rvalid_out <= 1'b0;
			mem_rdata_out <= 32'h0000_0000;
			left_q <= 5'h00;
			addr_q <= 32'h0000_0000;
			wait_q <= 2'h0;
		end else begin
			mem_ack_out <= 1'b0;
			mem_rvalid_out <= 1'b0;
			mem_rdata_out <= ~mem_rdata_out; // Never leave a stale beat on the bus
			wait_q <= wait_q + 2'h1;
			if (left_q != 5'h00) begin
				if (!slow_in || wait_q[0]) begin
					mem_rvalid_out <= 1'b1;
					mem_rdata_out <= ~addr_q;
					addr_q <= addr_q + WORD_STEP;
					left_q <= left_q - 5'h01;
				end
			end else if (mem_req_in && !mem_ack_out && (!slow_in || wait_q == 2'h3)) begin
				mem_ack_out <= 1'b1;
				left_q <= mem_cmd_in.beats;
				addr_q <= mem_cmd_in.addr;
			end
		end
	end
endmodule : memory_model

// >>> dv/testbench.sv
// Self-checking bench: register tasks and frame fetches.
// Assumes the checker binds itself and memory_model answers fetches.
`timescale 1ns/1ps
module testbench
	import cursor_dma_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic frame_start_in = 1'b0;
	logic slow = 1'b0;
	logic [31:0] reg_addr_in = '0;
	logic [31:0] reg_wdata_in = '0;
	logic [5:0] fifo_space_in = 6'h10;
	logic [31:0] reg_rdata_out, mem_rdata_in, v;
	logic mem_req_out, mem_ack_in, mem_rvalid_in, pixel_valid_out, format_valid_out, busy_out;
	logic [5:0] pixel_bits_out;
	mem_cmd_s mem_cmd_out;
	pixel_s pixel_out;
	irq_enable_s irq_enable_out;
	int miscompares = 0, compares = 0, pix_n = 0, lut_n = 0;
	logic [7:0] cmd_q[$], exp_q[$];
	int bpp_tab[14] = '{12, 16, 16, 16, 16, 18, 18, 19, 19, 24, 24, 25, 32, 32};
	logic [31:0] regs[6] = '{OFS_HEAD, OFS_FB_START, OFS_CONTROL, OFS_NEXT, OFS_BURST, OFS_FORMAT};
	always #12.5 sys_clk_in = ~sys_clk_in;
	cursor_layer_dma_fetch uut (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .frame_start_in, .frame_words_in(16'h001b),
		.lut_base_in(32'h0000_8000), .fifo_space_in, .mem_req_out, .mem_cmd_out, .mem_ack_in,
		.mem_rvalid_in, .mem_rdata_in, .pixel_valid_out, .pixel_out, .irq_enable_out,
		.pixel_bits_out, .format_valid_out, .busy_out);
	memory_model mem_i (.clk_in(sys_clk_in), .resetn_in, .slow_in(slow), .mem_req_in(mem_req_out),
		.mem_cmd_in(mem_cmd_out), .mem_ack_out(mem_ack_in), .mem_rvalid_out(mem_rvalid_in),
		.mem_rdata_out(mem_rdata_in));
	// Log accepted commands and delivered words
	always @(posedge sys_clk_in) begin
		if (mem_req_out && mem_ack_in) cmd_q.push_back({mem_cmd_out.burst, mem_cmd_out.beats});
		if (pixel_valid_out && pix_n == 0) v = pixel_out.data;
		if (pixel_valid_out) pix_n++;
		if (pixel_valid_out && pixel_out.from_lut) lut_n++;
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// Read in the cycle right after a write, to the same place
	task automatic wrrd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk("readback", e, reg_rdata_out);
	endtask : wrrd
	task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(n, e, reg_rdata_out);
	endtask : rdc
	// Starving the fifo first proves no request before the policy's room
	task automatic frame(input logic starve);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		frame_start_in <= 1'b1;
		@(posedge sys_clk_in);
		frame_start_in <= 1'b0;
		repeat (20) @(posedge sys_clk_in);
		fifo_space_in <= 6'h10;
		#1 if (starve) chk("early request", 32'h0, 32'(mem_req_out));
		while (busy_out !== 1'b0 && n < 3000) begin
			@(posedge sys_clk_in);
			n++;
		end
		chk("frame done", 32'h1, 32'(n < 3000));
	endtask : frame
	function automatic void plan(input int s, input int d, input int n);
		int cap, a, b;
		burst_e k;
		cap = (s == 0) ? 16 : (2 << s);
		exp_q.delete();
		while (n > 0) begin
			a = (n < cap) ? n : cap;
			b = (a >= 16) ? 16 : (a >= 8) ? 8 : (a >= 4) ? 4 : (a > 1 && d == 0) ? a : 1;
			k = (b == 16) ? burst_incr16 : (b == 8) ? burst_incr8 : (b == 4) ? burst_incr4 :
				(b > 1) ? burst_incr : burst_single;
			exp_q.push_back({k, 5'(b)});
			n -= b;
		end
	endfunction : plan
	task automatic complete_run();
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// Watchdog far beyond the expected few thousand cycles
	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1 chk("irq reset", 32'h7, 32'(irq_enable_out));
		chk("bpp reset", 32'd12, 32'(pixel_bits_out));
		foreach (regs[i]) rdc("reset value", regs[i], 32'h0000_0000);
		wrrd(OFS_HEAD, 32'hffff_ffff, 32'hffff_fffc);
		wrrd(OFS_FB_START, 32'h8765_4321, 32'h8765_4321);
		wrrd(OFS_NEXT, 32'h0000_2004, 32'h0000_2004);
		wrrd(OFS_BURST, 32'hffff_ffff, BURST_MASK);
		wrrd(OFS_FORMAT, 32'hffff_ffff, FORMAT_MASK);
		wrrd(32'hf803_8394, 32'hffff_ffff, 32'h0000_0000);
		wrrd(OFS_CONTROL, 32'h0000_0014, 32'h0000_0014);
		chk("irq decode", 32'h2, 32'(irq_enable_out));
		wrrd(OFS_CONTROL, 32'hffff_ffe8, 32'h0000_0028);
		chk("irq decode", 32'hd, 32'(irq_enable_out));
		wr(OFS_CONTROL, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			wr(OFS_FORMAT, 32'(i << 4));
			#30 chk("format ok", 32'(i < 14), 32'(format_valid_out));
			if (i < 14) chk("rgb bpp", bpp_tab[i], 32'(pixel_bits_out));
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_FORMAT, 32'(i << 8) | 32'h1);
			#30 chk("index bpp", 32'(1 << i), 32'(pixel_bits_out));
		end
		wr(OFS_FORMAT, 32'h0000_0000);
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 2; d++) begin
				wr(OFS_BURST, 32'(s << 4) | 32'(d << 8));
				plan(s, d, 27);
				cmd_q.delete();
				pix_n = 0;
				slow <= d[0];
				fifo_space_in <= 6'((s == 0 ? 1 : 2 << s) - 1);
				frame(1'b1);
				chk("pixel words", 32'd27, pix_n);
				chk("first pixel", ~32'h8765_4321, v);
				chk("commands", exp_q.size(), cmd_q.size());
				foreach (exp_q[i]) chk("burst", exp_q[i], cmd_q[i]);
			end
		end
		wr(OFS_FORMAT, 32'h0000_0001);
		for (int l = 0; l < 2; l++) begin
			wr(OFS_CONTROL, 32'(l << 1));
			lut_n = 0;
			pix_n = 0;
			frame(1'b0);
			chk("table words", 32'(2 * l), lut_n);
			chk("all words", 32'(27 + 2 * l), pix_n);
		end
		wr(OFS_FORMAT, 32'h0000_0000);
		rdc("events", OFS_EVENTS, 32'h0000_0004);
		wr(OFS_HEAD, 32'h0000_1000);
		wr(OFS_COMMAND, 32'h0000_0004);
		rdc("pending", OFS_CHAN_STATUS, 32'h0000_0004);
		wr(OFS_CONTROL, 32'h0000_0001);
		frame(1'b0);
		rdc("loaded start", OFS_FB_START, 32'hffff_efff);
		rdc("loaded ctrl", OFS_CONTROL, 32'h0000_003b);
		rdc("loaded next", OFS_NEXT, 32'hffff_eff7);
		chk("loaded irq", 32'h9, 32'(irq_enable_out));
		rdc("head events", OFS_EVENTS, 32'h0000_001c);
		rdc("events cleared", OFS_EVENTS, 32'h0000_0000);
		rdc("pending clear", OFS_CHAN_STATUS, 32'h0000_0000);
		complete_run();
	end
endmodule : testbench
